// File: bench/tb_wwdg_top.sv
// Self-checking testbench for the windowed watchdog block.
`timescale 1ns/10ps
module tb_wwdg_top;
  import wwdg_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        halt = 1'b0;
  logic        awv = 1'b0;
  logic        wv = 1'b0;
  logic        brdy = 1'b0;
  logic        arv = 1'b0;
  logic        rrdy = 1'b0;
  logic [7:0]  awa = 8'h00;
  logic [7:0]  ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic        awr, wrdy, bv, arr, rv, irq, rreq;
  logic [1:0]  br, rr;
  logic [31:0] rd;
  logic        irq_seen = 1'b0;
  logic        req_seen = 1'b0;
  int          n_fail = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [7:0]  t_addr [5] = '{STATUS_OFS, COUNT_OFS, CONTROL_OFS, 8'h10, 8'h40};
  logic [31:0] t_data [5] = '{STATUS_RESET, 32'h3F, CONTROL_RESET, 32'h0, 32'h0};
  logic [1:0]  t_resp [5] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR, RESP_SLVERR};
  int          divs [16] = '{1, 2, 4, 8, 16, 32, 64, 128, 192, 256, 384, 512, 768, 1024, 1536, 2048};

  wwdg_top DUT (.CLK(clk), .RESET_N(rst_n), .CPU_HALTED(halt), .TIMEOUT_RESET_SEEN(1'b0),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_AWPROT(3'h0),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy), .S_AXI_BRESP(br), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rrdy), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .COMPARE_IRQ(irq), .RESET_REQ(rreq));

  always #2.5 clk = ~clk;

  // Sticky flags catch short pulses that a register poll would miss.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    irq_seen <= rst_n && (irq_seen || irq);
    req_seen <= rst_n && (req_seen || rreq);
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_of_test;
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ad = 0;
    bit dd = 0;
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (awv && awr) begin
        ad = 1;
        awv <= 1'b0;
      end
      if (wv && wrdy) begin
        dd = 1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (!bv);
    brdy <= 1'b1;
    @(posedge clk);
    r = br;
    brdy <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rrdy <= 1'b1;
    @(posedge clk);
    d = rd;
    r = rr;
    rrdy <= 1'b0;
  endtask : rd_reg

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    logic [31:0] v, c1;
    logic [1:0]  r;
    int          t [3];
    do_reset();
    for (int i = 0; i < 5; i++) begin
      rd_reg(t_addr[i], v, r);
      chk(v, t_data[i]);
      chk(32'(r), 32'(t_resp[i]));
    end
    wr_reg(COUNT_OFS, 32'h0, r);
    wr_reg(8'h10, 32'h0, r);
    chk(32'(r), 32'(RESP_SLVERR));
    repeat (20) @(posedge clk);
    rd_reg(COUNT_OFS, v, r);
    chk(v, 32'h3F);
    wr_reg(CONTROL_OFS, 32'h0020_0103, r);
    chk(32'(r), 32'(RESP_OKAY));
    wr_reg(CONTROL_OFS, 32'h0, r);
    rd_reg(CONTROL_OFS, v, r);
    chk(v, 32'h0020_0103);
    while (!irq) @(posedge clk);
    rd_reg(STATUS_OFS, v, r);
    chk(32'(v[MATCH_BIT]), 32'h1);
    wr_reg(STATUS_OFS, 32'h1, r);
    rd_reg(STATUS_OFS, v, r);
    chk(32'(v[MATCH_BIT]), 32'h0);
    chk(32'(irq), 32'h0);
    while (!rreq) @(posedge clk);
    rd_reg(STATUS_OFS, v, r);
    chk(32'(v[TOUT_BIT]), 32'h1);
    // Interrupt off: the flag must still set while the line stays low.
    do_reset();
    wr_reg(CONTROL_OFS, 32'h0030_0401, r);
    do rd_reg(COUNT_OFS, v, r); while (v > 32'h30);
    rd_reg(STATUS_OFS, v, r);
    chk(32'(v[MATCH_BIT]), 32'h1);
    chk(32'(irq_seen), 32'h0);
    wr_reg(STATUS_OFS, 32'h0, r);
    rd_reg(STATUS_OFS, v, r);
    chk(32'(v[MATCH_BIT]), 32'h1);
    wr_reg(RELOAD_OFS, RELOAD_KEY, r);
    rd_reg(COUNT_OFS, v, r);
    chk(32'(v > 32'h30), 32'h1);
    chk(32'(req_seen), 32'h0);
    halt <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(COUNT_OFS, c1, r);
    repeat (64) @(posedge clk);
    rd_reg(COUNT_OFS, v, r);
    chk(v, c1);
    halt <= 1'b0;
    wr_reg(RELOAD_OFS, RELOAD_KEY, r);
    for (int k = 0; k < 20 && !req_seen; k++) @(posedge clk);
    chk(32'(req_seen), 32'h1);
    // Step spacing is measured by polling, so a few cycles of slack are allowed.
    for (int s = 0; s < 16; s++) begin
      do_reset();
      wr_reg(CONTROL_OFS, {20'h0, 4'(s), 8'h01}, r);
      rd_reg(COUNT_OFS, c1, r);
      for (int k = 0; k < 3; k++) begin
        do rd_reg(COUNT_OFS, v, r); while (v === c1);
        c1 = v;
        t[k] = cyc;
      end
      chk(32'((t[2] - t[1]) inside {[divs[s] - 7 : divs[s] + 7]}), 32'h1);
    end
    end_of_test();
  end
endmodule : tb_wwdg_top

// File: bench/wwdg_assertions.sv
// Port-level assertions for the windowed watchdog top module.
`timescale 1ns/10ps
module wwdg_assertions
  import wwdg_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        COMPARE_IRQ,
  input wire logic        RESET_REQ
);
  // ****************************************************************
  // Read address capture
  // ****************************************************************
  // The read answer carries no address, so the last accepted one is kept.
  logic [7:0] ra_q;
  logic [7:0] ra_d;
  always_comb ra_d = (S_AXI_ARVALID && S_AXI_ARREADY) ? S_AXI_ARADDR : ra_q;
  always_ff @(posedge CLK) ra_q <= RESET_N ? ra_d : 8'h00;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  a_reset_quiet: assert property ($rose(RESET_N) |-> !COMPARE_IRQ && !RESET_REQ)
    else $error("outputs active right after reset");
  a_req_four_cycles: assert property ($rose(RESET_REQ) |-> RESET_REQ[*4] ##1 !RESET_REQ)
    else $error("reset request pulse length wrong");
  a_bresp_held: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped early");
  a_rdata_held: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped early");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_count_upper_zero: assert property (S_AXI_RVALID && ra_q == COUNT_OFS |-> S_AXI_RDATA[31:6] == 26'h0)
    else $error("count register upper bits set");
  a_status_upper_zero: assert property (S_AXI_RVALID && ra_q == STATUS_OFS |-> S_AXI_RDATA[31:2] == 30'h0)
    else $error("status register upper bits set");
  a_unmapped_error: assert property (S_AXI_RVALID && ra_q > COUNT_OFS |-> S_AXI_RRESP == RESP_SLVERR)
    else $error("unmapped read not refused");

  c_reset_req: cover property ($rose(RESET_REQ));
  c_irq: cover property ($rose(COMPARE_IRQ));
  c_slverr: cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);
endmodule : wwdg_assertions

bind wwdg_top wwdg_assertions u_chk (.CLK, .RESET_N, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_ARADDR, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA,
  .S_AXI_RRESP, .COMPARE_IRQ, .RESET_REQ);

// File: design/wwdg_prescale.sv
// Prescaler producing one tick per selected number of clocks.
`timescale 1ns/10ps
module wwdg_prescale
  import wwdg_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  input  wire logic       run,
  input  wire logic [3:0] sel,
  output logic            tick
);
  logic [PRE_W-1:0] cnt_q;
  logic [PRE_W-1:0] cnt_d;
  logic             tick_d;

  function automatic logic [PRE_W-1:0] ratio_m1(input logic [3:0] s);
    case (s)
      4'h0: ratio_m1 = 11'd0;
      4'h1: ratio_m1 = 11'd1;
      4'h2: ratio_m1 = 11'd3;
      4'h3: ratio_m1 = 11'd7;
      4'h4: ratio_m1 = 11'd15;
      4'h5: ratio_m1 = 11'd31;
      4'h6: ratio_m1 = 11'd63;
      4'h7: ratio_m1 = 11'd127;
      4'h8: ratio_m1 = 11'd191;
      4'h9: ratio_m1 = 11'd255;
      4'hA: ratio_m1 = 11'd383;
      4'hB: ratio_m1 = 11'd511;
      4'hC: ratio_m1 = 11'd767;
      4'hD: ratio_m1 = 11'd1023;
      4'hE: ratio_m1 = 11'd1535;
      default: ratio_m1 = 11'd2047;
    endcase
  endfunction : ratio_m1

  // Count stops while not running, so a halt does not lose a partial period.
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (run) begin
      if (cnt_q >= ratio_m1(sel)) begin // see R1 see R8
        cnt_d  = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 11'd1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick  <= tick_d;
    end
  end
endmodule : wwdg_prescale

// File: design/wwdg_sync.sv
// Two-flop synchroniser for the debug halt level.
`timescale 1ns/10ps
module wwdg_sync (
  input  wire logic CLK,
  input  wire logic RESET_N,
  input  wire logic din,
  output logic      dout
);
  logic s1_q;
  logic s2_q;
  logic s1_d;
  logic s2_d;

  always_comb begin
    s1_d = din;
    s2_d = s1_q;
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign dout = s2_q;
endmodule : wwdg_sync

// File: design/wwdg_top.sv
// Windowed watchdog with AXI4-Lite register slave.
// Function
// R1 - Prescale codes 1100 to 1111 divide counting clock by 768, 1024, 1536, 2048.
// R2 - Compare-match interrupt is sent only while compare interrupt enable is 1.
// R3 - Counter enable 0 holds the down counter, 1 lets it count.
// R4 - Status bit 1 shows a watchdog time-out reset happened; write 1 clears.
// R5 - Status bit 0 sets when count equals window compare; write 1 clears.
// R6 - Count register mirrors live 6-bit count; upper bits zero; read-only.
// R7 - After reset count reads 0x3F and status reads zero.
// R8 - Prescale codes 0000 to 1011 divide by 1 up to 512 in order.
// R9 - Reload allowed only when count is at or below compare, else reset at once.
// R10 - Control register takes only its first write after reset.
// R11 - With debug-halt disable 0 the counter pauses during debugger halt.
// R12 - Reaching zero without reload requests system reset and sets time-out flag.
`timescale 1ns/10ps
module wwdg_top
  import wwdg_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        CPU_HALTED,
  input  wire logic        TIMEOUT_RESET_SEEN,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic [2:0]  S_AXI_AWPROT,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  output logic [1:0]       S_AXI_BRESP,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic [2:0]  S_AXI_ARPROT,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             COMPARE_IRQ,
  output logic             RESET_REQ
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic        aw_have_q, aw_have_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic        w_have_q, w_have_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0]  w_strb_q, w_strb_d;
  logic        bvalid_d, awready_d, wready_d;
  logic [1:0]  bresp_d;
  wwdg_bus_t   rd_q, rd_d;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_d;
  logic        arready_d;

  logic [31:0] ctrl_q, ctrl_d;
  logic        locked_q, locked_d;
  logic [5:0]  count_q, count_d;
  logic        match_q, match_d;
  logic        tout_q, tout_d;
  logic        irq_d;
  logic        rst_d;
  logic [2:0]  rst_cnt_q, rst_cnt_d;
  logic        tout_seen_q;

  logic        halted;
  logic        tick;
  logic        run;
  logic        wr_fire;
  logic [5:0]  win;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  wwdg_sync u_sync (
    .CLK     (CLK),
    .RESET_N (RESET_N),
    .din     (CPU_HALTED),
    .dout    (halted)
  );

  // A halted core freezes the prescaler too, unless debug-halt disable is set.
  assign run = ctrl_q[EN_BIT] && (ctrl_q[DBG_BIT] || !halted); // see R3 see R11
  assign win = ctrl_q[WIN_MSB:WIN_LSB];

  wwdg_prescale u_pre (
    .CLK     (CLK),
    .RESET_N (RESET_N),
    .run     (run),
    .sel     (ctrl_q[PSEL_MSB:PSEL_LSB]),
    .tick    (tick)
  );

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  assign wr_fire = aw_have_q && w_have_q && !S_AXI_BVALID;

  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d  = w_have_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    awready_d = 1'b0;
    wready_d  = 1'b0;
    bvalid_d  = S_AXI_BVALID;
    bresp_d   = S_AXI_BRESP;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_have_d = 1'b1;
      aw_addr_d = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_have_d = 1'b1;
      w_data_d = S_AXI_WDATA;
      w_strb_d = S_AXI_WSTRB;
    end
    if (!aw_have_d && !S_AXI_AWREADY && S_AXI_AWVALID) begin
      awready_d = 1'b1;
    end
    if (!w_have_d && !S_AXI_WREADY && S_AXI_WVALID) begin
      wready_d = 1'b1;
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (aw_addr_q <= COUNT_OFS && aw_addr_q[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
      awready_d = 1'b0;
      wready_d  = 1'b0;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      bvalid_d = 1'b0;
    end
  end

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  always_comb begin
    rd_d      = rd_q;
    arready_d = 1'b0;
    rdata_d   = S_AXI_RDATA;
    rresp_d   = S_AXI_RRESP;
    case (rd_q)
      WWDG_IDLE: begin
        if (S_AXI_ARVALID && !S_AXI_ARREADY) begin
          arready_d = 1'b1;
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
          rd_d    = WWDG_RESP;
          rresp_d = RESP_OKAY;
          case (S_AXI_ARADDR)
            RELOAD_OFS:  rdata_d = 32'h00000000;
            CONTROL_OFS: rdata_d = ctrl_q;
            STATUS_OFS:  rdata_d = {30'h0, tout_q, match_q};
            COUNT_OFS:   rdata_d = {26'h0, count_q}; // see R6
            default: begin
              rdata_d = 32'h00000000;
              rresp_d = RESP_SLVERR;
            end
          endcase
        end
      end
      WWDG_RESP: begin
        if (S_AXI_RREADY) begin
          rd_d = WWDG_IDLE;
        end
      end
      default: rd_d = WWDG_IDLE;
    endcase
  end

  // ****************************************************************
  // Watchdog core
  // ****************************************************************
  always_comb begin
    ctrl_d    = ctrl_q;
    locked_d  = locked_q;
    count_d   = count_q;
    match_d   = match_q;
    tout_d    = tout_q;
    rst_d     = 1'b0;
    rst_cnt_d = rst_cnt_q;
    if (wr_fire && aw_addr_q == CONTROL_OFS && !locked_q) begin // see R10
      ctrl_d   = merge(ctrl_q, w_data_q, w_strb_q) & CONTROL_RESET | 
                 (merge(ctrl_q, w_data_q, w_strb_q) & 32'h80000F03);
      locked_d = 1'b1;
    end
    if (tick && count_q != COUNT_ZERO) begin // see R3
      count_d = count_q - 6'd1;
    end
    // Clear first, then set, so an event in the clearing cycle survives.
    if (wr_fire && aw_addr_q == STATUS_OFS && w_strb_q[0]) begin
      if (w_data_q[MATCH_BIT]) match_d = 1'b0; // see R5
      if (w_data_q[TOUT_BIT])  tout_d  = 1'b0; // see R4
    end
    if (tick && count_d == win && count_q != win) begin // see R5
      match_d = 1'b1;
    end
    if (wr_fire && aw_addr_q == RELOAD_OFS && w_data_q == RELOAD_KEY) begin
      if (count_q > win) begin // see R9
        rst_cnt_d = 3'(RST_PULSE_CYC);
      end else begin
        count_d = COUNT_FULL;
      end
    end
    // A tick at zero is the time-out; the flag lives in this block so it outlasts
    // the system reset when the chip keeps the block out of that reset.
    if (tick && count_q == COUNT_ZERO) begin // see R12
      rst_cnt_d = 3'(RST_PULSE_CYC);
      tout_d    = 1'b1;
    end
    if (tout_seen_q) begin // see R4
      tout_d = 1'b1;
    end
    // A request raised while a pulse runs merges into it, so the pulse never stretches.
    if (rst_cnt_q != 3'd0) begin // see R12
      rst_d     = 1'b1;
      rst_cnt_d = rst_cnt_q - 3'd1;
    end
    irq_d = match_d && ctrl_d[IE_BIT]; // see R2
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      aw_have_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_have_q      <= 1'b0;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
      rd_q          <= WWDG_IDLE;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= RESP_OKAY;
      ctrl_q        <= CONTROL_RESET;
      locked_q      <= 1'b0;
      count_q       <= COUNT_FULL; // see R7
      match_q       <= STATUS_RESET[MATCH_BIT]; // see R7
      tout_q        <= STATUS_RESET[TOUT_BIT];
      tout_seen_q   <= 1'b0;
      COMPARE_IRQ   <= 1'b0;
      RESET_REQ     <= 1'b0;
      rst_cnt_q     <= 3'd0;
    end else begin
      aw_have_q     <= aw_have_d;
      aw_addr_q     <= aw_addr_d;
      w_have_q      <= w_have_d;
      w_data_q      <= w_data_d;
      w_strb_q      <= w_strb_d;
      S_AXI_AWREADY <= awready_d;
      S_AXI_WREADY  <= wready_d;
      S_AXI_BVALID  <= bvalid_d;
      S_AXI_BRESP   <= bresp_d;
      rd_q          <= rd_d;
      S_AXI_ARREADY <= arready_d;
      S_AXI_RVALID  <= (rd_d == WWDG_RESP);
      S_AXI_RDATA   <= rdata_d;
      S_AXI_RRESP   <= rresp_d;
      ctrl_q        <= ctrl_d;
      locked_q      <= locked_d;
      count_q       <= count_d;
      match_q       <= match_d;
      tout_q        <= tout_d;
      tout_seen_q   <= 1'b0;
      COMPARE_IRQ   <= irq_d;
      RESET_REQ     <= rst_d;
      rst_cnt_q     <= rst_cnt_d;
    end
  end

  // strap_done_q sets one cycle after the release of reset; the strap itself is never stored.
  logic strap_done_q;
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
    end
  end
  logic strap_unused;
  assign strap_unused = strap_done_q & TIMEOUT_RESET_SEEN & (^S_AXI_AWPROT) & (^S_AXI_ARPROT);

endmodule : wwdg_top

// File: shared/wwdg_pkg.sv
// Package with register map, field layout and timing constants of the windowed watchdog.
package wwdg_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0]  RELOAD_OFS      = 8'h00;
  localparam logic [7:0]  CONTROL_OFS     = 8'h04;
  localparam logic [7:0]  STATUS_OFS      = 8'h08;
  localparam logic [7:0]  COUNT_OFS       = 8'h0C;
  localparam logic [31:0] RELOAD_KEY      = 32'h00005AA5;
  localparam logic [31:0] CONTROL_RESET   = 32'h003F0800;
  localparam logic [31:0] STATUS_RESET    = 32'h00000000;
  localparam logic [5:0]  COUNT_FULL      = 6'h3F;
  localparam logic [5:0]  COUNT_ZERO      = 6'h00;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int EN_BIT      = 0;
  localparam int IE_BIT      = 1;
  localparam int PSEL_LSB    = 8;
  localparam int PSEL_MSB    = 11;
  localparam int WIN_LSB     = 16;
  localparam int WIN_MSB     = 21;
  localparam int DBG_BIT     = 31;
  localparam int MATCH_BIT   = 0;
  localparam int TOUT_BIT    = 1;

  // ****************************************************************
  // Prescaler and bus answers
  // ****************************************************************
  localparam int          PRE_W     = 11;
  localparam logic [1:0]  RESP_OKAY = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam int          RST_PULSE_NS = 20;
  localparam int          CLK_PERIOD_NS = 5;
  localparam int          RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    WWDG_IDLE  = 2'b00,
    WWDG_RESP  = 2'b01
  } wwdg_bus_t;

endpackage : wwdg_pkg
